// file: hdl/sbc_mode_state_machine.sv
// operating-mode sequencer: modes, reset/int/safe open-drain pins, watchdog windows
// assumes serial decoding elsewhere; commands arrive as one-cycle strobes on the clock
`timescale 1ns/10ps
module sbc_mode_state_machine #(
  parameter int unsigned TICK_CYCLES = smsm_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              sys_rst,
  // decoded commands
  input  wire logic              cmd_refresh,
  input  wire logic              cmd_wrong,
  input  wire logic              cmd_sleep_on,
  input  wire logic              cmd_sleep_off,
  input  wire logic              cmd_flash_exit,
  input  wire logic              cmd_dbg_exit,
  input  wire logic              sec_req,
  input  wire logic [1:0]        sec_target,
  input  wire logic              sec_resp,
  input  wire logic [7:0]        sec_data,
  output logic      [7:0]        sec_code,
  // one-time configuration
  input  wire logic              cfg_wr,
  input  wire logic [1:0]        cfg_idx,
  input  wire logic [7:0]        cfg_wdata,
  output logic      [7:0]        cfg_rdata,
  output logic                   cfg_wr_refused,
  // settings
  input  wire logic [14:0]       wd_period_ms,
  input  wire logic              nreq_short_en,
  input  wire logic [14:0]       nreq_short_ms,
  input  wire logic              rst_long_sel,
  input  wire logic              flash_half_int_en,
  input  wire logic              int_pulse_sel,
  input  wire logic [7:0]        int_pulse_len,
  input  wire logic [3:0]        int_src,
  input  wire logic [3:0]        int_en,
  input  wire logic              int_clr,
  input  wire logic              can_sup_req,
  input  wire logic              pass_req,
  // monitors and wake
  input  wire logic              vdd_uv,
  input  wire logic              fault_event,
  input  wire logic              safe_clr,
  input  wire logic              debug_select_pin,
  input  wire logic              wake_flags_set,
  input  wire logic              failsafe_sleep,
  input  wire logic [4:0]        wake_src,
  input  wire logic              batfail_clr,
  // pins and status
  output logic                   rst_o,
  output logic                   rst_oe,
  output logic                   int_o,
  output logic                   int_oe,
  output logic                   safe_o,
  output logic                   safe_oe,
  output smsm_pkg::smsm_mode_t   mode,
  output logic                   debug_mode,
  output logic                   batfail,
  output logic      [4:0]        wake_rec,
  output logic                   func_en,
  output logic                   can_supply_en,
  output logic                   aux_supply_en,
  output logic                   pass_en
);
  import smsm_pkg::*;

  localparam int unsigned CW = $clog2(TICK_CYCLES);

  if (TICK_CYCLES < 2) begin : g_tick_chk
    $error("TICK_CYCLES must be at least 2");
  end

  smsm_mode_t     mode_q, mode_d;
  logic [CW-1:0]  cyc_q;
  logic [14:0]    tmr_q;
  logic [7:0]     cfg_q [4];
  logic [7:0]     lfsr_q, code_q;
  logic           sec_arm_q;
  logic [1:0]     sec_tgt_q;
  logic           dbg_q, first_q, rst_long_q, short_q, pend_q, safe_q, bat_q;
  logic [7:0]     pcnt_q;
  logic [4:0]     wake_q;

  wire tick    = (cyc_q == CW'(TICK_CYCLES - 1));
  wire entry   = (mode_d != mode_q);
  wire in_cfg  = (mode_q == SMSM_CONFIG);
  wire wake_ev = (mode_q inside {SMSM_SLEEP_ON, SMSM_SLEEP_OFF}) && (wake_src != 5'h00);

  // secured response must be inverted code
  wire sec_ok   = sec_arm_q && sec_resp && (sec_data == ~code_q) && (mode_q == SMSM_NORMAL);
  wire wd_wrong = cmd_wrong && !dbg_q;

  wire [14:0] nreq_lim  = short_q ? nreq_short_ms : NREQ_MS;
  // long length never leaks into initial reset
  wire [14:0] rst_lim   = (rst_long_q && (mode_q == SMSM_RESET)) ? RST_LONG_MS : RST_MS;
  wire [14:0] half_norm = {1'b0, wd_period_ms[14:1]};
  wire        t_end     = tick && (tmr_q == rst_lim - 15'h0001);
  wire        cfg_to    = tick && (tmr_q == CFG_MS - 15'h0001) && !dbg_q;
  wire        nreq_to   = tick && (tmr_q == nreq_lim - 15'h0001) && !dbg_q;
  wire        norm_to   = tick && (tmr_q == wd_period_ms - 15'h0001) && !dbg_q;
  wire        norm_early = cmd_refresh && (tmr_q < half_norm) && !dbg_q;
  wire        flash_to  = tick && (tmr_q == FLASH_MS - 15'h0001) && !dbg_q;
  wire        flash_half = tick && (mode_q == SMSM_FLASH) && (tmr_q == {1'b0, FLASH_MS[14:1]} - 15'h0001);
  // sleep only with wake flags cleared
  wire        sleep_ok  = !wake_flags_set;
  // undervoltage entry without a coinciding wrong refresh sets long reset choice
  wire        uv_hit    = vdd_uv && (mode_q inside {SMSM_NORMAL, SMSM_NREQ, SMSM_SLEEP_ON, SMSM_FLASH});
  // debug exit by command or pin drop
  wire        dbg_drop  = dbg_q && (cmd_dbg_exit || !debug_select_pin);
  // good refresh or debug exit restarts the period
  wire        wd_kick   = cmd_refresh && (((mode_q == SMSM_NORMAL) && (tmr_q >= half_norm)) || (mode_q == SMSM_FLASH));
  wire        restart   = entry || wd_kick || dbg_drop;

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      SMSM_INIT_RST: begin
        if (t_end) mode_d = SMSM_CONFIG;
      end
      SMSM_CONFIG: begin
        if (cmd_refresh) mode_d = SMSM_NORMAL;
        else if (cfg_to) mode_d = SMSM_INIT_RST;
      end
      SMSM_NORMAL: begin
        if (uv_hit || wd_wrong || norm_to || norm_early) mode_d = SMSM_RESET;
        else if (sec_ok && sec_tgt_q == SEC_RESET) mode_d = SMSM_RESET;
        else if (sec_ok && sec_tgt_q == SEC_CONFIG) mode_d = SMSM_CONFIG;
        else if (sec_ok && sec_tgt_q == SEC_FLASH) mode_d = SMSM_FLASH;
        else if (cmd_sleep_on && sleep_ok) mode_d = SMSM_SLEEP_ON;
        else if ((cmd_sleep_off || failsafe_sleep) && sleep_ok) mode_d = SMSM_SLEEP_OFF;
        else if (dbg_q && !debug_select_pin && !cmd_dbg_exit) mode_d = SMSM_RESET;
      end
      SMSM_FLASH: begin
        if (uv_hit || wd_wrong || flash_to || cmd_flash_exit) mode_d = SMSM_RESET;
      end
      SMSM_NREQ: begin
        if (uv_hit || nreq_to) mode_d = SMSM_RESET;
        else if (cmd_refresh) mode_d = SMSM_NORMAL;
      end
      SMSM_RESET: begin
        if (t_end) mode_d = SMSM_NREQ;
      end
      SMSM_SLEEP_ON: begin
        if (uv_hit) mode_d = SMSM_RESET;
        else if (wake_ev) mode_d = SMSM_NREQ;
      end
      SMSM_SLEEP_OFF: begin
        if (wake_ev) mode_d = SMSM_RESET;
      end
      default: mode_d = SMSM_INIT_RST;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mode_q <= SMSM_INIT_RST;
      cyc_q  <= '0;
      tmr_q  <= '0;
    end else begin
      mode_q <= mode_d;
      cyc_q  <= (restart || tick) ? '0 : cyc_q + CW'(1);
      tmr_q  <= restart ? 15'h0000 : (tick ? tmr_q + 15'h0001 : tmr_q);
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rst_long_q <= 1'b0;
      short_q    <= 1'b0;
      wake_q     <= 5'h00;
    end else begin
      if (entry && mode_d == SMSM_RESET) rst_long_q <= uv_hit && rst_long_sel && !wd_wrong;
      if (entry && mode_d == SMSM_NREQ) short_q <= (mode_q == SMSM_SLEEP_ON) && nreq_short_en;
      if (wake_ev) wake_q <= wake_src;
    end
  end

  wire cfg_take = cfg_wr && in_cfg;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) cfg_q[i] <= CFG_RST;
      cfg_wr_refused <= 1'b0;
    end else begin
      if (cfg_take) cfg_q[cfg_idx] <= cfg_wdata;
      cfg_wr_refused <= cfg_wr && !in_cfg;
    end
  end
  assign cfg_rdata = cfg_q[cfg_idx];

  // fresh random code per secured exercise
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lfsr_q    <= LFSR_SEED;
      code_q    <= 8'h00;
      sec_arm_q <= 1'b0;
      sec_tgt_q <= SEC_RESET;
    end else begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      if (sec_req) begin
        code_q    <= lfsr_q;
        sec_tgt_q <= sec_target;
        sec_arm_q <= 1'b1;
      end else if (sec_resp || entry) begin
        sec_arm_q <= 1'b0;
      end
    end
  end
  assign sec_code = code_q;

  // debug sampled once on leaving initial reset
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dbg_q   <= 1'b0;
      first_q <= 1'b1;
      bat_q   <= 1'b1;
    end else begin
      if (first_q && mode_q == SMSM_INIT_RST && t_end) begin
        dbg_q   <= debug_select_pin && !cmd_dbg_exit;
        first_q <= 1'b0;
      end else if (dbg_drop) begin
        dbg_q <= 1'b0;
      end
      // power-loss flag, set at power-on only
      if (batfail_clr) bat_q <= 1'b0;
    end
  end

  wire int_ev = |(int_src & int_en) || (flash_half && flash_half_int_en) || wake_ev;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pend_q <= 1'b0;
      pcnt_q <= 8'h00;
    end else begin
      // set wins over clear
      pend_q <= int_ev || (pend_q && !int_clr);
      if (int_ev) pcnt_q <= (int_pulse_len == 8'h00) ? 8'h01 : int_pulse_len;
      else if (pcnt_q != 8'h00) pcnt_q <= pcnt_q - 8'h01;
    end
  end

  // fault latches safe low, set wins
  always_ff @(posedge clock) begin
    if (sys_rst) safe_q <= 1'b0;
    else safe_q <= fault_event || (safe_q && !safe_clr);
  end

  // open-drain pins only ever drive low
  wire int_low = int_pulse_sel ? (pcnt_q != 8'h00) : pend_q;
  assign rst_o   = 1'b0;
  assign int_o   = 1'b0;
  assign safe_o  = 1'b0;
  // reset held low in reset modes
  assign rst_oe  = (mode_q == SMSM_INIT_RST) || (mode_q == SMSM_RESET);
  assign int_oe  = int_low;
  assign safe_oe = safe_q;

  assign mode       = mode_q;
  assign debug_mode = dbg_q;
  assign batfail    = bat_q;
  assign wake_rec   = wake_q;
  // peripherals off in config and reset states, except can supply in config while debug
  wire run = (mode_q == SMSM_NORMAL) || (mode_q == SMSM_FLASH) || (mode_q == SMSM_NREQ);
  assign func_en       = run;
  assign can_supply_en = (run || (in_cfg && dbg_q)) && (can_sup_req || dbg_q);
  assign aux_supply_en = run;
  // pass control normal and flash only
  assign pass_en = pass_req && ((mode_q == SMSM_NORMAL) || (mode_q == SMSM_FLASH));

  property p_cfg_to;
    @(posedge clock) disable iff (sys_rst) (in_cfg && cfg_to && !cmd_refresh) |=> mode_q == SMSM_INIT_RST;
  endproperty
  a_cfg_to: assert property (p_cfg_to) else $error("config timeout missed");
  property p_cfg_lock;
    @(posedge clock) disable iff (sys_rst) (cfg_wr && !in_cfg) |=> $stable(cfg_q[$past(cfg_idx)]) && cfg_wr_refused;
  endproperty
  a_cfg_lock: assert property (p_cfg_lock) else $error("config written outside config");
  property p_rst_pin;
    @(posedge clock) disable iff (sys_rst) (mode_q == SMSM_RESET) |-> rst_oe && !rst_o;
  endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("reset pin released in reset");
  property p_pass;
    @(posedge clock) disable iff (sys_rst) !(mode_q inside {SMSM_NORMAL, SMSM_FLASH}) |-> !pass_en;
  endproperty
  a_pass: assert property (p_pass) else $error("pass control on in wrong mode");
  property p_dbg_safe;
    @(posedge clock) disable iff (sys_rst) (dbg_q && mode_q == SMSM_NORMAL && !vdd_uv && !sec_ok && debug_select_pin)
      |=> mode_q != SMSM_RESET;
  endproperty
  a_dbg_safe: assert property (p_dbg_safe) else $error("watchdog reset in debug");
  property p_sleep_refuse;
    @(posedge clock) disable iff (sys_rst) (mode_q == SMSM_NORMAL && wake_flags_set) |=> !(mode_q inside {SMSM_SLEEP_ON, SMSM_SLEEP_OFF});
  endproperty
  a_sleep_refuse: assert property (p_sleep_refuse) else $error("sleep entered with wake flags");
  property p_sleep_wake;
    @(posedge clock) disable iff (sys_rst) (mode_q == SMSM_SLEEP_OFF && wake_src != 5'h00)
      |=> mode_q == SMSM_RESET && wake_rec == $past(wake_src);
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep-off wake not through reset");
  property p_safe;
    @(posedge clock) disable iff (sys_rst) fault_event |=> safe_oe [*2];
  endproperty
  a_safe: assert property (p_safe) else $error("safe not driven after fault");
  property p_int_lvl;
    @(posedge clock) disable iff (sys_rst) (int_ev && !int_pulse_sel && !$past(int_pulse_sel)) |=> int_oe || int_pulse_sel;
  endproperty
  a_int_lvl: assert property (p_int_lvl) else $error("interrupt level not asserted");
  property p_rst_to_nreq;
    @(posedge clock) disable iff (sys_rst) (mode_q == SMSM_RESET && t_end) |=> mode_q == SMSM_NREQ;
  endproperty
  a_rst_to_nreq: assert property (p_rst_to_nreq) else $error("reset not followed by normal-request");
  c_cfg_normal: cover property (@(posedge clock) disable iff (sys_rst) in_cfg && cmd_refresh ##1 mode_q == SMSM_NORMAL);
  c_flash: cover property (@(posedge clock) disable iff (sys_rst) mode_q == SMSM_FLASH);
  c_sleep_wake: cover property (@(posedge clock) disable iff (sys_rst) mode_q == SMSM_SLEEP_OFF ##1 mode_q == SMSM_RESET);
endmodule : sbc_mode_state_machine

// file: hdl/smsm_pkg.sv
// constants and state encoding for the operating-mode sequencer
// assumes one 50 MHz clock and decoded serial commands arriving as one-cycle strobes
// Contract
// - enabled interrupt drives int low as level or as selectable-length pulse
// - open-drain safe output pulled low once a fault event is seen
// - power-on enters initial reset, reset low 1 ms, defaults, power-loss flag
// - initial reset moves to config; host configures within 256 ms
// - four one-time config registers writable only in config state
// - refresh in config goes normal; 256 ms timeout returns to initial reset
// - config register read-back served in config state
// - config state re-entered only through a secured command
// - config state keeps peripherals off; can supply off unless debug
// - watchdog failure or supply undervoltage enters reset mode from run modes
// - reset lasts 1 ms; longer only after undervoltage entry
// - after reset or sleep wake go normal-request; refresh or 256 ms timeout; nreq_short_ms after sleep-on wake when nreq_short_en
// - pass-transistor control enabled only in normal and flash
// - normal mode resets on wrong or missing refresh
// - plain command enters sleep modes; reset, config, flash need secured command
// - flash watchdog 32 s; miss, wrong refresh or exit command give reset
// - optional interrupt at half of flash watchdog period
// - debug entered when high voltage seen on debug pin after power-up
// - debug suppresses every watchdog consequence; can supply on by default
// - debug left on pin voltage removal or exit command
// - sleep entry refused while wake flags remain set
// - sleep-off wake leads to reset then normal-request, source recorded
// - exit command wins over debug pin voltage
// - secured command needs inverted copy of presented random code
package smsm_pkg;
  typedef enum logic [2:0] {
    SMSM_INIT_RST  = 3'b000,
    SMSM_CONFIG    = 3'b001,
    SMSM_NORMAL    = 3'b011,
    SMSM_FLASH     = 3'b010,
    SMSM_SLEEP_ON  = 3'b110,
    SMSM_NREQ      = 3'b111,
    SMSM_RESET     = 3'b101,
    SMSM_SLEEP_OFF = 3'b100
  } smsm_mode_t;

  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned TICK_US     = 1000;
  localparam int unsigned TICK_CYC    = CLK_HZ / 1_000_000 * TICK_US;
  localparam logic [14:0] RST_MS      = 15'h0001;
  localparam logic [14:0] CFG_MS      = 15'h0100;
  localparam logic [14:0] NREQ_MS     = 15'h0100;
  localparam logic [14:0] FLASH_MS    = 15'h7D00;
  localparam logic [14:0] RST_LONG_MS = 15'h0010;
  localparam logic [7:0]  CFG_RST     = 8'h00;
  localparam logic [7:0]  LFSR_SEED   = 8'hA5;
  localparam logic [1:0]  SEC_RESET   = 2'h0;
  localparam logic [1:0]  SEC_CONFIG  = 2'h1;
  localparam logic [1:0]  SEC_FLASH   = 2'h2;
endpackage : smsm_pkg

// file: sim/sbc_mode_state_machine_tb.sv
// scenario bench for the operating-mode sequencer
// assumes a 1 ms tick shortened to 4 clocks; secured handshake comes from smsm_host_model
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module sbc_mode_state_machine_tb;
  import smsm_pkg::*;
  localparam int TK = 4;
  logic        clock = 1'b0, sys_rst = 1'b1, go = 1'b0, corrupt = 1'b0;
  logic        cmd_refresh = 1'b0, cmd_wrong = 1'b0, cmd_sleep_on = 1'b0, cmd_sleep_off = 1'b0;
  logic        cmd_flash_exit = 1'b0, cmd_dbg_exit = 1'b0, cfg_wr = 1'b0, nreq_short_en = 1'b0;
  logic        rst_long_sel = 1'b0, flash_half_int_en = 1'b0, int_pulse_sel = 1'b0, int_clr = 1'b0;
  logic        can_sup_req = 1'b1, pass_req = 1'b1, vdd_uv = 1'b0, fault_event = 1'b0, safe_clr = 1'b0;
  logic        debug_select_pin = 1'b0, wake_flags_set = 1'b0, failsafe_sleep = 1'b0, batfail_clr = 1'b0;
  logic [1:0]  cfg_idx = 2'h0, target = 2'h0, sec_target;
  logic [7:0]  cfg_wdata = 8'h00, int_pulse_len = 8'h03, sec_data, sec_code, cfg_rdata;
  logic [14:0] wd_period_ms = 15'h0008, nreq_short_ms = 15'h0004;
  logic [3:0]  int_src = 4'h0, int_en = 4'h0;
  logic [4:0]  wake_src = 5'h00, wake_rec;
  logic        sec_req, sec_resp, cfg_wr_refused, rst_o, rst_oe, int_o, int_oe, safe_o, safe_oe;
  logic        debug_mode, batfail, func_en, can_supply_en, aux_supply_en, pass_en;
  smsm_mode_t  mode;
  int          bad_count = 0, checks_done = 0, n = 0;

  always #10 clock = ~clock;

  sbc_mode_state_machine #(.TICK_CYCLES(TK)) dut (
    .clock, .sys_rst, .cmd_refresh, .cmd_wrong, .cmd_sleep_on, .cmd_sleep_off, .cmd_flash_exit,
    .cmd_dbg_exit, .sec_req, .sec_target, .sec_resp, .sec_data, .sec_code, .cfg_wr, .cfg_idx,
    .cfg_wdata, .cfg_rdata, .cfg_wr_refused, .wd_period_ms, .nreq_short_en, .nreq_short_ms,
    .rst_long_sel, .flash_half_int_en, .int_pulse_sel, .int_pulse_len, .int_src, .int_en, .int_clr,
    .can_sup_req, .pass_req, .vdd_uv, .fault_event, .safe_clr, .debug_select_pin, .wake_flags_set,
    .failsafe_sleep, .wake_src, .batfail_clr, .rst_o, .rst_oe, .int_o, .int_oe, .safe_o, .safe_oe,
    .mode, .debug_mode, .batfail, .wake_rec, .func_en, .can_supply_en, .aux_supply_en, .pass_en);
  smsm_host_model host (.clock, .go, .target, .corrupt, .sec_req, .sec_target, .sec_resp,
    .sec_data, .sec_code);

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
  endtask : pulse

  // bounded wait; n returns the cycles spent
  task automatic wait_mode(input smsm_mode_t m, input int lim);
    n = 0;
    while (mode !== m && n < lim) begin
      @(negedge clock);
      n++;
    end
    if (mode !== m) begin
      bad_count++;
      $display("[ERR] %0t mode wait timed out", $time);
      end_sim();
    end
  endtask : wait_mode

  task automatic s_init();
    `CHK(mode, SMSM_INIT_RST)
    `CHK({rst_oe, batfail, int_oe, safe_oe}, 4'hC)
    wait_mode(SMSM_CONFIG, 20);
    `CHK(n >= TK - 1 && n <= TK + 2, 1'b1)
    wait_mode(SMSM_INIT_RST, 1100);
    `CHK(n >= 256 * TK - 3 && n <= 256 * TK + 2, 1'b1)
    wait_mode(SMSM_CONFIG, 20);
  endtask : s_init

  task automatic s_config();
    cfg_idx = 2'h2;
    cfg_wdata = 8'h5A;
    pulse(cfg_wr);
    `CHK({cfg_rdata, cfg_wr_refused}, 9'h0B4)
    `CHK({func_en, can_supply_en, aux_supply_en, pass_en}, 4'h0)
    pulse(cmd_refresh);
    `CHK({mode, func_en, pass_en}, {SMSM_NORMAL, 2'h3})
    cfg_wdata = 8'hC3;
    pulse(cfg_wr);
    `CHK({cfg_rdata, cfg_wr_refused}, 9'h0B5)
  endtask : s_config

  task automatic s_secured();
    target = SEC_FLASH;
    corrupt = 1'b1;
    pulse(go);
    repeat (8) @(negedge clock);
    `CHK(mode, SMSM_NORMAL)
    corrupt = 1'b0;
    flash_half_int_en = 1'b1;
    pulse(go);
    wait_mode(SMSM_FLASH, 10);
    `CHK(pass_en, 1'b1)
    pulse(cmd_flash_exit);
    `CHK({mode, rst_oe}, {SMSM_RESET, 1'b1})
    wait_mode(SMSM_NREQ, 40);
    `CHK(n >= TK - 1 && n <= TK + 2 && pass_en === 1'b0, 1'b1)
    wait_mode(SMSM_RESET, 1100);
    `CHK(n >= 256 * TK - 3 && n <= 256 * TK + 2, 1'b1)
    wait_mode(SMSM_NREQ, 40);
    pulse(cmd_refresh);
  endtask : s_secured

  task automatic s_watchdog();
    // refresh before the half period is as bad as none
    pulse(cmd_refresh);
    `CHK(mode, SMSM_RESET)
    wait_mode(SMSM_NREQ, 40);
    pulse(cmd_refresh);
    `CHK(mode, SMSM_NORMAL)
    // refresh inside the open window restarts the period
    repeat (6 * TK) @(negedge clock);
    pulse(cmd_refresh);
    wait_mode(SMSM_RESET, 60);
    `CHK(n >= 8 * TK - 3 && n <= 8 * TK + 2, 1'b1)
    wait_mode(SMSM_NREQ, 40);
    pulse(cmd_refresh);
    rst_long_sel = 1'b1;
    pulse(cmd_wrong);
    wait_mode(SMSM_NREQ, 40);
    `CHK(n >= TK - 2 && n <= TK + 1, 1'b1)
    pulse(cmd_refresh);
    pulse(vdd_uv);
    `CHK(mode, SMSM_RESET)
    wait_mode(SMSM_NREQ, 100);
    `CHK(n >= 16 * TK - 3 && n <= 16 * TK + 2, 1'b1)
    rst_long_sel = 1'b0;
    pulse(cmd_refresh);
  endtask : s_watchdog

  task automatic s_sleep();
    wake_flags_set = 1'b1;
    pulse(cmd_sleep_on);
    `CHK(mode, SMSM_NORMAL)
    wake_flags_set = 1'b0;
    pulse(cmd_sleep_off);
    `CHK({mode, aux_supply_en, can_supply_en, pass_en}, {SMSM_SLEEP_OFF, 3'h0})
    wake_src = 5'h04;
    @(negedge clock);
    wake_src = 5'h00;
    `CHK(mode, SMSM_RESET)
    wait_mode(SMSM_NREQ, 40);
    `CHK(wake_rec, 5'h04)
    pulse(cmd_refresh);
    nreq_short_en = 1'b1;
    pulse(cmd_sleep_on);
    `CHK({mode, pass_en}, {SMSM_SLEEP_ON, 1'b0})
    wake_src = 5'h01;
    @(negedge clock);
    wake_src = 5'h00;
    `CHK(mode, SMSM_NREQ)
    wait_mode(SMSM_RESET, 40);
    `CHK(n >= 4 * TK - 3 && n <= 4 * TK + 2, 1'b1)
    nreq_short_en = 1'b0;
  endtask : s_sleep

  task automatic s_pins();
    // wake events left a level interrupt pending
    `CHK(int_oe, 1'b1)
    pulse(int_clr);
    int_en = 4'h1;
    int_src = 4'h2;
    repeat (3) @(negedge clock);
    `CHK(int_oe, 1'b0)
    int_src = 4'h1;
    repeat (3) @(negedge clock);
    int_src = 4'h0;
    `CHK(int_oe, 1'b1)
    pulse(int_clr);
    @(negedge clock);
    `CHK(int_oe, 1'b0)
    int_pulse_sel = 1'b1;
    int_src = 4'h1;
    @(negedge clock);
    int_src = 4'h0;
    n = 0;
    repeat (8) begin
      if (int_oe === 1'b1) n++;
      @(negedge clock);
    end
    `CHK(n, 3)
    pulse(fault_event);
    repeat (3) @(negedge clock);
    `CHK({safe_o, safe_oe}, 2'h1)
    pulse(safe_clr);
    @(negedge clock);
    `CHK(safe_oe, 1'b0)
  endtask : s_pins

  task automatic s_debug();
    can_sup_req = 1'b0;
    debug_select_pin = 1'b1;
    sys_rst = 1'b1;
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    wait_mode(SMSM_CONFIG, 20);
    `CHK({debug_mode, can_supply_en, batfail}, 3'h7)
    repeat (300 * TK) @(negedge clock);
    `CHK(mode, SMSM_CONFIG)
    pulse(cmd_refresh);
    pulse(cmd_wrong);
    repeat (20 * TK) @(negedge clock);
    `CHK(mode, SMSM_NORMAL)
    target = SEC_CONFIG;
    pulse(go);
    wait_mode(SMSM_CONFIG, 10);
    cfg_wdata = 8'h3C;
    pulse(cfg_wr);
    `CHK({cfg_rdata, cfg_wr_refused}, 9'h078)
    pulse(cmd_dbg_exit);
    `CHK({debug_mode, mode}, {1'b0, SMSM_CONFIG})
    wait_mode(SMSM_INIT_RST, 1100);
    `CHK(n >= 256 * TK - 3 && n <= 256 * TK + 2, 1'b1)
  endtask : s_debug

  initial begin
    repeat (12) @(negedge clock);
    sys_rst = 1'b0;
    s_init();
    s_config();
    s_secured();
    s_watchdog();
    s_sleep();
    s_pins();
    s_debug();
    end_sim();
  end
endmodule : sbc_mode_state_machine_tb

// file: sim/smsm_host_model.sv
// microcontroller side of the secured mode-change handshake
// assumes go is raised for one cycle at a falling edge; lines change at falling edges
`timescale 1ns/10ps
module smsm_host_model (
  // clock
  input  wire logic       clock,
  // bench control
  input  wire logic       go,
  input  wire logic [1:0] target,
  input  wire logic       corrupt,
  // secured command lines
  output logic            sec_req,
  output logic [1:0]      sec_target,
  output logic            sec_resp,
  output logic [7:0]      sec_data,
  input  wire logic [7:0] sec_code
);
  // one process owns every line the model drives
  initial begin
    sec_req    = 1'b0;
    sec_target = 2'h0;
    sec_resp   = 1'b0;
    sec_data   = 8'h00;
    forever begin
      @(posedge clock);
      if (go) begin
        @(negedge clock);
        sec_req    = 1'b1;
        sec_target = target;
        @(negedge clock);
        sec_req    = 1'b0;
        @(negedge clock);
        sec_resp   = 1'b1;
        sec_data   = corrupt ? sec_code : ~sec_code;
        @(negedge clock);
        sec_resp   = 1'b0;
      end else begin
        // idle data churns so a stale byte never passes for an answer
        @(negedge clock);
        sec_data   = sec_data + 8'h3B;
      end
    end
  end
endmodule : smsm_host_model
